// >>> cfc_pkg.sv
// package of register map, field layout and reset values for the coherency flow control block
package cfc_pkg;

    // ==========================================================
    // register map
    localparam int          CFC_ADDR_W       = 40;
    localparam int          CFC_DATA_W       = 64;
    localparam logic [39:0] CFC_TUNING_ADDR  = 40'hFF_FED0_C000;

    // ==========================================================
    // field positions of interface_tuning_control
    localparam int CFC_MARK_W            = 4;
    localparam int CFC_HOLD_EN_BIT       = 28;
    localparam int CFC_SKIP_EN_BIT       = 25;
    localparam int CFC_WQ_HIGH_LSB       = 20;
    localparam int CFC_WQ_LOW_LSB        = 16;
    localparam int CFC_WMAP_HIGH_LSB     = 12;
    localparam int CFC_WMAP_LOW_LSB      = 8;
    localparam int CFC_RMAP_HIGH_LSB     = 4;
    localparam int CFC_RMAP_LOW_LSB      = 0;

    // ==========================================================
    // reset values
    localparam logic       CFC_HOLD_EN_RST   = 1'h0;
    localparam logic       CFC_SKIP_EN_RST   = 1'h0;
    localparam logic [3:0] CFC_HIGH_MARK_RST = 4'h8;
    localparam logic [3:0] CFC_LOW_MARK_RST  = 4'h4;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic       read_return_hold_enable;
        logic       medium_read_skip_enable;
        logic [3:0] write_priority_high_mark;
        logic [3:0] write_priority_low_mark;
        logic [3:0] write_map_high_mark;
        logic [3:0] write_map_low_mark;
        logic [3:0] read_map_high_mark;
        logic [3:0] read_map_low_mark;
    } cfc_ctrl_t;

    typedef struct packed {
        logic                  wr;
        logic                  rd;
        logic [CFC_ADDR_W-1:0] addr;
        logic [CFC_DATA_W-1:0] wdata;
    } cfc_bus_req_t;

endpackage : cfc_pkg

// >>> cfc_hyst.sv
// hysteresis flag: sets above a high mark, clears at or below a low mark
`timescale 1ns/1ps
`default_nettype none

module cfc_hyst
    import cfc_pkg::*;
#(
    parameter int OCC_W = 5
)
(
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    // occupancy and marks
    input  wire logic [OCC_W-1:0] occupancy,
    input  wire logic [3:0]       high_mark,
    input  wire logic [3:0]       low_mark,
    // flag
    output var  logic             flag_r
);

    // ==========================================================
    // compare
    wire logic [OCC_W-1:0] high_wide;
    wire logic [OCC_W-1:0] low_wide;
    wire logic             above_high;
    wire logic             at_or_below_low;
    logic                  flag_nxt;

    assign high_wide       = OCC_W'(high_mark);
    assign low_wide        = OCC_W'(low_mark);
    assign above_high      = occupancy > high_wide;
    assign at_or_below_low = occupancy <= low_wide;

    // set wins if marks are programmed inverted, so the flag never chatters off
    always_comb
    begin
        flag_nxt = flag_r;
        if (at_or_below_low)
            flag_nxt = 1'b0;
        if (above_high)
            flag_nxt = 1'b1;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            flag_r <= 1'b0;
        else
            flag_r <= flag_nxt;
    end

endmodule // cfc_hyst

`default_nettype wire

// >>> cfc_flow_control.sv
// coherency flow control: tuning register, read return hold, read skip and hysteresis flags
`timescale 1ns/1ps
`default_nettype none

module cfc_flow_control
    import cfc_pkg::*;
#(
    parameter int NUM_PROC = 4,
    parameter int OCC_W    = 5
)
(
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  reset_n,
    // register port
    input  wire logic [CFC_ADDR_W-1:0] reg_addr,
    input  wire logic [CFC_DATA_W-1:0] reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output var  logic [CFC_DATA_W-1:0] reg_rdata,
    // bus arbitration
    input  wire logic [NUM_PROC-1:0]   proc_arb_req,
    input  wire logic                  io_arb_req,
    // read requests from the bus side
    input  wire logic                  read_req_valid,
    output var  logic                  read_issue_direct,
    output var  logic                  read_queue_push,
    // occupancies
    input  wire logic [OCC_W-1:0]      write_queue_count,
    input  wire logic [OCC_W-1:0]      write_map_count,
    input  wire logic [OCC_W-1:0]      read_map_count,
    // flow control outputs
    output var  logic                  read_return_hold,
    output var  logic                  write_priority,
    output var  logic                  none_allowed_fc,
    output var  logic                  returns_only_fc
);

    // ==========================================================
    // elaboration checks
    if (OCC_W < 4 || OCC_W > 16)
    begin : g_bad_occ
        $error("OCC_W must lie in 4..16");
    end
    if (NUM_PROC < 1)
    begin : g_bad_proc
        $error("NUM_PROC must be at least 1");
    end

    // ==========================================================
    // register port decode
    cfc_bus_req_t          bus_req;
    cfc_ctrl_t             ctrl_r;
    cfc_ctrl_t             ctrl_nxt;
    logic [CFC_DATA_W-1:0] rdata_r;
    logic [CFC_DATA_W-1:0] rdata_nxt;
    wire logic             hit;
    wire logic             wr_hit;
    wire logic [CFC_DATA_W-1:0] ctrl_word;
    wire logic [CFC_DATA_W-1:0] wd;

    assign bus_req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
    assign hit     = bus_req.addr == CFC_TUNING_ADDR;
    assign wr_hit  = bus_req.wr && hit;
    assign wd      = bus_req.wdata;

    // reserved bits read zero
    assign ctrl_word = {35'h0,
                        ctrl_r.read_return_hold_enable,
                        2'h0,
                        ctrl_r.medium_read_skip_enable,
                        1'h0,
                        ctrl_r.write_priority_high_mark,
                        ctrl_r.write_priority_low_mark,
                        ctrl_r.write_map_high_mark,
                        ctrl_r.write_map_low_mark,
                        ctrl_r.read_map_high_mark,
                        ctrl_r.read_map_low_mark};

    // no pending-traffic interlock here: software owns that ordering
    assign ctrl_nxt = wr_hit ? '{
        read_return_hold_enable:  wd[CFC_HOLD_EN_BIT],
        medium_read_skip_enable:  wd[CFC_SKIP_EN_BIT],
        write_priority_high_mark: wd[CFC_WQ_HIGH_LSB   +: CFC_MARK_W],
        write_priority_low_mark:  wd[CFC_WQ_LOW_LSB    +: CFC_MARK_W],
        write_map_high_mark:      wd[CFC_WMAP_HIGH_LSB +: CFC_MARK_W],
        write_map_low_mark:       wd[CFC_WMAP_LOW_LSB  +: CFC_MARK_W],
        read_map_high_mark:       wd[CFC_RMAP_HIGH_LSB +: CFC_MARK_W],
        read_map_low_mark:        wd[CFC_RMAP_LOW_LSB  +: CFC_MARK_W]} : ctrl_r;

    // unmapped reads answer zero; data stands one cycle only
    assign rdata_nxt = (bus_req.rd && hit) ? ctrl_word : '0;

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_r  <= '{read_return_hold_enable:  CFC_HOLD_EN_RST,
                         medium_read_skip_enable:  CFC_SKIP_EN_RST,
                         write_priority_high_mark: CFC_HIGH_MARK_RST,
                         write_priority_low_mark:  CFC_LOW_MARK_RST,
                         write_map_high_mark:      CFC_HIGH_MARK_RST,
                         write_map_low_mark:       CFC_LOW_MARK_RST,
                         read_map_high_mark:       CFC_HIGH_MARK_RST,
                         read_map_low_mark:        CFC_LOW_MARK_RST};
            rdata_r <= '0;
        end
        else
        begin
            ctrl_r  <= ctrl_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    // ==========================================================
    // arbitration pin synchronisers
    logic [NUM_PROC-1:0] arb_meta_r;
    logic [NUM_PROC-1:0] arb_sync_r;

    for (genvar p = 0; p < NUM_PROC; p++)
    begin : g_arb_sync
        always_ff @(posedge sys_clk or negedge reset_n)
        begin
            if (!reset_n)
            begin
                arb_meta_r[p] <= 1'b0;
                arb_sync_r[p] <= 1'b0;
            end
            else
            begin
                arb_meta_r[p] <= proc_arb_req[p];
                arb_sync_r[p] <= arb_meta_r[p];
            end
        end
    end

    // ==========================================================
    // read return hold and read skip
    wire logic any_arb;
    wire logic hold_nxt;
    wire logic direct_nxt;
    wire logic push_nxt;
    logic      hold_r;
    logic      direct_r;
    logic      push_r;

    assign any_arb    = (|arb_sync_r) || io_arb_req;
    assign hold_nxt   = ctrl_r.read_return_hold_enable && any_arb;
    // skip path saves the queue stage; one flop either way
    assign direct_nxt = read_req_valid && ctrl_r.medium_read_skip_enable;
    assign push_nxt   = read_req_valid && !ctrl_r.medium_read_skip_enable;

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hold_r   <= 1'b0;
            direct_r <= 1'b0;
            push_r   <= 1'b0;
        end
        else
        begin
            hold_r   <= hold_nxt;
            direct_r <= direct_nxt;
            push_r   <= push_nxt;
        end
    end

    assign read_return_hold  = hold_r;
    assign read_issue_direct = direct_r;
    assign read_queue_push   = push_r;

    // ==========================================================
    // hysteresis flags, reset deasserted
    cfc_hyst #(.OCC_W(OCC_W)) u_write_priority
    (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .occupancy (write_queue_count),
        .high_mark (ctrl_r.write_priority_high_mark),
        .low_mark  (ctrl_r.write_priority_low_mark),
        .flag_r    (write_priority)
    );

    // release compares against the high mark, so the low mark field is stored only
    cfc_hyst #(.OCC_W(OCC_W)) u_none_allowed
    (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .occupancy (write_map_count),
        .high_mark (ctrl_r.write_map_high_mark),
        .low_mark  (ctrl_r.write_map_high_mark),
        .flag_r    (none_allowed_fc)
    );

    cfc_hyst #(.OCC_W(OCC_W)) u_returns_only
    (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .occupancy (read_map_count),
        .high_mark (ctrl_r.read_map_high_mark),
        .low_mark  (ctrl_r.read_map_low_mark),
        .flag_r    (returns_only_fc)
    );

endmodule // cfc_flow_control

`default_nettype wire

// >>> cfc_flow_control_asserts.sv
// checker of the flow control outputs against a shadow of the tuning word
`timescale 1ns/1ps
`default_nettype none
module cfc_flow_control_asserts
    import cfc_pkg::*;
#(
    parameter int NUM_PROC = 4,
    parameter int OCC_W    = 5
)
(
    // clock and reset
    input wire logic                  sys_clk,
    input wire logic                  reset_n,
    // register port
    input wire logic [CFC_ADDR_W-1:0] reg_addr,
    input wire logic [CFC_DATA_W-1:0] reg_wdata,
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire logic [CFC_DATA_W-1:0] reg_rdata,
    // traffic
    input wire logic                  io_arb_req,
    input wire logic                  read_req_valid,
    input wire logic                  read_issue_direct,
    input wire logic                  read_queue_push,
    input wire logic [OCC_W-1:0]      write_queue_count,
    input wire logic [OCC_W-1:0]      write_map_count,
    input wire logic [OCC_W-1:0]      read_map_count,
    // flags
    input wire logic                  read_return_hold,
    input wire logic                  write_priority,
    input wire logic                  none_allowed_fc,
    input wire logic                  returns_only_fc
);
    // ========
    // shadow word, writable bits only
    logic [63:0] ctl_r;
    wire         hit = reg_addr == CFC_TUNING_ADDR;
    always_ff @(posedge sys_clk or negedge reset_n)
        if (!reset_n)
            ctl_r <= 64'h84_8484;
        else if (reg_wr && hit)
            ctl_r <= reg_wdata & 64'h12FF_FFFF;
    // ========
    // properties
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    a_rd_word: assert property (reg_rd && hit |=> reg_rdata == $past(ctl_r))
        else $error("read word wrong");
    a_hold_io: assert property (ctl_r[28] && io_arb_req |=> read_return_hold)
        else $error("hold missing");
    a_hold_off: assert property (!ctl_r[28] |=> !read_return_hold)
        else $error("hold while disabled");
    a_skip_path: assert property (read_req_valid |=>
        read_issue_direct == $past(ctl_r[25]) && read_queue_push != $past(ctl_r[25]))
        else $error("read path wrong");
    a_wprio_set: assert property (write_queue_count > ctl_r[23:20] |=> write_priority)
        else $error("priority not set");
    a_wprio_keep: assert property (write_priority
        && write_queue_count > ctl_r[19:16] |=> write_priority) else $error("priority dropped");
    a_wprio_clr: assert property (write_queue_count <= ctl_r[19:16]
        && write_queue_count <= ctl_r[23:20] |=> !write_priority) else $error("prio stuck");
    a_none_set: assert property (write_map_count > ctl_r[15:12] |=> none_allowed_fc)
        else $error("none flow not set");
    a_none_clr: assert property (write_map_count <= ctl_r[15:12] |=> !none_allowed_fc)
        else $error("none flow stuck");
    a_ret_set: assert property (read_map_count > ctl_r[7:4] |=> returns_only_fc)
        else $error("returns flow not set");
    a_ret_clr: assert property (read_map_count <= ctl_r[3:0]
        && read_map_count <= ctl_r[7:4] |=> !returns_only_fc) else $error("returns flow stuck");
    a_flags_init: assert property ($rose(reset_n) |-> !write_priority
        && !none_allowed_fc && !returns_only_fc) else $error("flag up after reset");
    c_prio_drop: cover property (write_priority ##1 !write_priority);
    c_none_on: cover property (none_allowed_fc);
    c_hold_on: cover property (read_return_hold);
endmodule // cfc_flow_control_asserts
`default_nettype wire

// >>> cfc_far_agent.sv
// far side model: bus agents and queue occupancies, registered once
`timescale 1ns/1ps
`default_nettype none
module cfc_far_agent
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    // scenario commands
    input  wire logic [4:0] arb_cmd,
    input  wire logic [4:0] wq_cmd,
    input  wire logic [4:0] wm_cmd,
    input  wire logic [4:0] rm_cmd,
    // towards the block
    output var  logic [3:0] proc_arb_req,
    output var  logic       io_arb_req,
    output var  logic [4:0] write_queue_count,
    output var  logic [4:0] write_map_count,
    output var  logic [4:0] read_map_count
);
    // queues are empty and nobody arbitrates while in reset
    always_ff @(posedge sys_clk or negedge reset_n)
        if (!reset_n)
            {io_arb_req, proc_arb_req, write_queue_count, write_map_count, read_map_count} <= '0;
        else
            {io_arb_req, proc_arb_req, write_queue_count, write_map_count, read_map_count}
                <= {arb_cmd, wq_cmd, wm_cmd, rm_cmd};
endmodule // cfc_far_agent
`default_nettype wire

// >>> tb_top.sv
// self-checking testbench of the coherency flow control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import cfc_pkg::*;
    logic        sys_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, read_req_valid = 0;
    logic        io_arb_req, read_issue_direct, read_queue_push, read_return_hold, rd_d = 0;
    logic        write_priority, none_allowed_fc, returns_only_fc;
    logic [39:0] reg_addr = '0;
    logic [63:0] reg_wdata = '0, reg_rdata, seed = 64'h40;
    logic [3:0]  proc_arb_req;
    logic [4:0]  arb_cmd = '0, wq_cmd = '0, wm_cmd = '0, rm_cmd = '0;
    logic [4:0]  write_queue_count, write_map_count, read_map_count;
    logic [63:0] exp_q[$];
    int          mismatches = 0, checks_done = 0, cyc = 0;
    // counts and expected {priority, none, returns}
    logic [17:0] tv [4] = '{{15'h2529, 3'h7}, {15'h1505, 3'h5}, {15'h1124, 3'h2}, {15'h2008, 3'h0}};
    cfc_flow_control cfc_flow_control_i (.sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .proc_arb_req, .io_arb_req, .read_req_valid, .read_issue_direct,
        .read_queue_push, .write_queue_count, .write_map_count, .read_map_count,
        .read_return_hold, .write_priority, .none_allowed_fc, .returns_only_fc);
    cfc_far_agent cfc_far_agent_i (.sys_clk, .reset_n, .arb_cmd, .wq_cmd, .wm_cmd, .rm_cmd,
        .proc_arb_req, .io_arb_req, .write_queue_count, .write_map_count, .read_map_count);
    always #5 sys_clk = ~sys_clk;
    function automatic logic [63:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 7;
        seed ^= seed << 17;
        return seed;
    endfunction
    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            $display("BAD %0t got %h want %h", $time, got, exp);
            mismatches++;
        end
    endtask
    task automatic end_sim();
        if (mismatches == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // strobes get a one-cycle gap so no signal is assigned twice in a step
    task automatic acc(input logic w, input logic [39:0] a, input logic [63:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        if (!w)
            exp_q.push_back(d);
        @(posedge sys_clk);
        {reg_wr, reg_rd} <= 2'b00;
        @(posedge sys_clk);
    endtask
    task automatic pulse(input logic [1:0] exp);
        read_req_valid <= 1'b1;
        @(posedge sys_clk);
        read_req_valid <= 1'b0;
        @(posedge sys_clk);
        cmp({read_issue_direct, read_queue_push}, exp);
    endtask
    always @(posedge sys_clk)
    begin
        if (rd_d)
            cmp(reg_rdata, exp_q.pop_front());
        rd_d <= reg_rd;
        if (++cyc == 5000)
        begin
            mismatches++;
            end_sim();
        end
    end
    initial
    begin
        logic [63:0] d;
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        // programmed with queues empty, before any traffic
        acc(1'b0, CFC_TUNING_ADDR, 64'h84_8484);
        acc(1'b0, CFC_TUNING_ADDR + 40'h8, 64'h0);
        acc(1'b1, CFC_TUNING_ADDR + 40'h8, '1);
        acc(1'b0, CFC_TUNING_ADDR, 64'h84_8484);
        repeat (4)
        begin
            d = xs();
            acc(1'b1, CFC_TUNING_ADDR, d);
            acc(1'b0, CFC_TUNING_ADDR, d & 64'h12FF_FFFF);
        end
        acc(1'b1, CFC_TUNING_ADDR, 64'h84_8484);
        foreach (tv[i])
        begin
            {wq_cmd, wm_cmd, rm_cmd} <= tv[i][17:3];
            repeat (3) @(posedge sys_clk);
            cmp({write_priority, none_allowed_fc, returns_only_fc}, tv[i][2:0]);
        end
        pulse(2'b01);
        arb_cmd <= 5'h10;
        acc(1'b1, CFC_TUNING_ADDR, 64'h1284_8484);
        // hold flop follows the new enable on the edge at which acc returns
        @(posedge sys_clk);
        cmp(read_return_hold, 1'b1);
        pulse(2'b10);
        arb_cmd <= 5'h02;
        repeat (6) @(posedge sys_clk);
        cmp(read_return_hold, 1'b1);
        acc(1'b1, CFC_TUNING_ADDR, 64'h84_8484);
        @(posedge sys_clk);
        cmp(read_return_hold, 1'b0);
        end_sim();
    end
endmodule // tb_top
bind cfc_flow_control cfc_flow_control_asserts #(.NUM_PROC(NUM_PROC), .OCC_W(OCC_W)) chk_i (
    .sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .io_arb_req,
    .read_req_valid, .read_issue_direct, .read_queue_push, .write_queue_count,
    .write_map_count, .read_map_count, .read_return_hold, .write_priority,
    .none_allowed_fc, .returns_only_fc);
`default_nettype wire
